// >>> logic/dpcm_consts.svh
// Constants for the dual-port burst counter and mailbox block
`ifndef DPCM_CONSTS_SVH
`define DPCM_CONSTS_SVH
`define DPCM_ADDR_W 18
`define DPCM_MBOX_RIGHT 18'h3ffff
`define DPCM_MBOX_LEFT 18'h3fffe
`define DPCM_MASK_RST 18'h3ffff
`define DPCM_CNT_RST 18'h00000
`define DPCM_MIRROR_RST 18'h00000
`define DPCM_PORT_L 0
`define DPCM_PORT_R 1
`endif

// >>> logic/dpcm_pkg.sv
// Types and shared decode for the dual-port burst counter and mailbox block
`include "dpcm_consts.svh"
package dpcm_pkg;

	typedef logic [`DPCM_ADDR_W-1:0] dpcm_addr_t;

	typedef enum logic [3:0] {
		DPCM_OP_CNT_RST  = 4'b0000,
		DPCM_OP_CNT_LOAD = 4'b0001,
		DPCM_OP_CNT_RDBK = 4'b0010,
		DPCM_OP_CNT_INC  = 4'b0011,
		DPCM_OP_CNT_HOLD = 4'b0100,
		DPCM_OP_MSK_RST  = 4'b0101,
		DPCM_OP_MSK_LOAD = 4'b0110,
		DPCM_OP_MSK_RDBK = 4'b0111,
		DPCM_OP_RSVD     = 4'b1000
	} dpcm_op_t;

	typedef struct packed {
		dpcm_addr_t cnt;
		dpcm_addr_t mask;
		dpcm_addr_t mirror;
		logic       wrap_n;
		dpcm_addr_t rb_data;
		logic       rb_oe_n;
		logic       dq_float;
		logic       arr_we;
		logic       arr_re;
	} dpcm_port_t;

	typedef struct packed {
		dpcm_port_t [1:0] port;
	} dpcm_top_st_t;

	typedef struct packed {
		logic [1:0] flag_n;
	} dpcm_mbox_st_t;

	// Clear beats strobe and enable; the select picks counter or mask
	function automatic dpcm_op_t dpcm_decode(
		input logic sel,
		input logic clr_n,
		input logic ads_n,
		input logic en_n
	);
		dpcm_op_t op;
		op = DPCM_OP_RSVD;
		if (sel && !clr_n)
			op = DPCM_OP_CNT_RST;
		else if (sel)
			op = ads_n ? (en_n ? DPCM_OP_CNT_HOLD : DPCM_OP_CNT_INC)
			           : (en_n ? DPCM_OP_CNT_RDBK : DPCM_OP_CNT_LOAD);
		else if (!clr_n)
			op = DPCM_OP_MSK_RST;
		else if (!ads_n)
			op = en_n ? DPCM_OP_MSK_RDBK : DPCM_OP_MSK_LOAD;
		return op;
	endfunction : dpcm_decode

endpackage : dpcm_pkg

// >>> logic/dpcm_port_access.sv
// Access qualification and mailbox hit detection for one port
`timescale 1ns/100ps
module dpcm_port_access
	import dpcm_pkg::*;
(
	input  wire logic       read_not_write_i,
	input  wire logic       chip_select_low_active_n_i,
	input  wire logic       chip_select_high_active_i,
	input  wire logic       byte_lane_enable_lo_n_i,
	input  wire logic       byte_lane_enable_hi_n_i,
	input  wire logic       access_ok_i,
	input  wire dpcm_addr_t eff_addr_i,
	input  wire dpcm_addr_t own_box_i,
	input  wire dpcm_addr_t other_box_i,
	output logic            enabled_o,
	output logic            write_o,
	output logic            read_o,
	output logic            wr_other_box_o,
	output logic            rd_own_box_o
);
	logic lane_w;

	// A cycle with no byte lane moves nothing and touches no flag
	assign lane_w         = !byte_lane_enable_lo_n_i || !byte_lane_enable_hi_n_i;
	assign enabled_o      = !chip_select_low_active_n_i && chip_select_high_active_i;
	assign write_o        = enabled_o && lane_w && access_ok_i && !read_not_write_i;
	assign read_o         = enabled_o && lane_w && access_ok_i && read_not_write_i;
	assign wr_other_box_o = write_o && (eff_addr_i == other_box_i);
	assign rd_own_box_o   = read_o && (eff_addr_i == own_box_i);
endmodule : dpcm_port_access

// >>> logic/dpcm_mailbox.sv
// Mailbox flags shared by the two ports
`timescale 1ns/100ps
module dpcm_mailbox
	import dpcm_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [1:0] set_i,
	input  wire logic [1:0] clr_i,
	output logic      [1:0] flag_n_o
);
	dpcm_mbox_st_t st_r;
	dpcm_mbox_st_t st_nxt;

	// A message landing as the owner reads keeps the flag low
	always_comb
	begin
		st_nxt = st_r;
		for (int i = 0; i < 2; i++)
		begin
			if (set_i[i])
				st_nxt.flag_n[i] = 1'b0;
			else if (clr_i[i])
				st_nxt.flag_n[i] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_r <= '{flag_n: 2'h3};
		else if (ce_i)
			st_r <= st_nxt;
	end

	assign flag_n_o = st_r.flag_n;
endmodule : dpcm_mailbox

// >>> logic/dpcm_top.sv
// Burst counters, mask and mirror registers and mailbox flags of both ports
`timescale 1ns/100ps
// Overview of operation
// - Global reset zeroes counters, sets masks ones.
// - Global reset drives all flags high.
// - Top word right mailbox, next left.
// - Writing other port's mailbox drives its flag low.
// - Owner reading own mailbox returns flag high unless other port writes it same cycle.
// - Flags follow the acting port's edge directly.
// - Wrong-owner read or write leaves flag alone.
// - Counter controls on clock, ignore chip selects.
// - Counter clear with select high wins.
// - Counter reset clears unmasked counter, mirror bits.
// - Load puts address into counter.
// - Mirror holds last loaded counter value, less unmasked bits a counter reset clears.
// - Increment advances counter, array uses counter.
// - Only unmasked bits count; masked bit0 steps two.
// - Counter readback drives counter on address.
// - Hold keeps all three registers.
// - Mask reset sets mask all ones.
// - Mask load takes address; mask otherwise stable except at mask reset.
// - Mask readback drives mask on address.
// - Increment reloads counter from mirror at wrap.
// - All unmasked ones wraps to mirror value.
// - Wrap flag low after increment reaches all-ones; loads, resets set high.
// - Readback shows next edge; data lines float only if the port is enabled.
module dpcm_top
	import dpcm_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,

	// Left port, index 0
	input  wire logic       l_read_not_write_i,
	input  wire logic       l_chip_select_low_active_n_i,
	input  wire logic       l_chip_select_high_active_i,
	input  wire logic       l_byte_lane_enable_lo_n_i,
	input  wire logic       l_byte_lane_enable_hi_n_i,
	input  wire logic       l_counter_or_mask_sel_i,
	input  wire logic       l_counter_clear_n_i,
	input  wire logic       l_address_strobe_n_i,
	input  wire logic       l_count_enable_n_i,
	input  wire dpcm_addr_t l_addr_i,
	output dpcm_addr_t      l_addr_o,
	output logic            l_addr_oe_n_o,
	output logic            l_dq_float_o,
	output dpcm_addr_t      l_array_addr_o,
	output logic            l_array_we_o,
	output logic            l_array_re_o,
	output logic            l_mailbox_flag_n_o,
	output logic            l_wrap_flag_n_o,

	// Right port, index 1
	input  wire logic       r_read_not_write_i,
	input  wire logic       r_chip_select_low_active_n_i,
	input  wire logic       r_chip_select_high_active_i,
	input  wire logic       r_byte_lane_enable_lo_n_i,
	input  wire logic       r_byte_lane_enable_hi_n_i,
	input  wire logic       r_counter_or_mask_sel_i,
	input  wire logic       r_counter_clear_n_i,
	input  wire logic       r_address_strobe_n_i,
	input  wire logic       r_count_enable_n_i,
	input  wire dpcm_addr_t r_addr_i,
	output dpcm_addr_t      r_addr_o,
	output logic            r_addr_oe_n_o,
	output logic            r_dq_float_o,
	output dpcm_addr_t      r_array_addr_o,
	output logic            r_array_we_o,
	output logic            r_array_re_o,
	output logic            r_mailbox_flag_n_o,
	output logic            r_wrap_flag_n_o
);

	dpcm_top_st_t     st_r;
	dpcm_top_st_t     st_nxt;

	logic       [1:0] rnw_w;
	logic       [1:0] cs_lo_n_w;
	logic       [1:0] cs_hi_w;
	logic       [1:0] be_lo_n_w;
	logic       [1:0] be_hi_n_w;
	logic       [1:0] sel_w;
	logic       [1:0] clr_n_w;
	logic       [1:0] ads_n_w;
	logic       [1:0] en_n_w;
	dpcm_addr_t [1:0] addr_w;

	dpcm_op_t   [1:0] op_w;
	dpcm_addr_t [1:0] cnt_next_w;
	logic       [1:0] access_ok_w;
	logic       [1:0] enabled_w;
	logic       [1:0] write_w;
	logic       [1:0] read_w;
	logic       [1:0] wr_other_w;
	logic       [1:0] rd_own_w;
	logic       [1:0] mbox_set_w;
	logic       [1:0] mbox_flag_n_w;
	dpcm_addr_t [1:0] own_box_w;
	dpcm_addr_t [1:0] other_box_w;

	// Left port is index 0, right port index 1
	assign rnw_w     = {r_read_not_write_i, l_read_not_write_i};
	assign cs_lo_n_w = {r_chip_select_low_active_n_i, l_chip_select_low_active_n_i};
	assign cs_hi_w   = {r_chip_select_high_active_i, l_chip_select_high_active_i};
	assign be_lo_n_w = {r_byte_lane_enable_lo_n_i, l_byte_lane_enable_lo_n_i};
	assign be_hi_n_w = {r_byte_lane_enable_hi_n_i, l_byte_lane_enable_hi_n_i};
	assign sel_w     = {r_counter_or_mask_sel_i, l_counter_or_mask_sel_i};
	assign clr_n_w   = {r_counter_clear_n_i, l_counter_clear_n_i};
	assign ads_n_w   = {r_address_strobe_n_i, l_address_strobe_n_i};
	assign en_n_w    = {r_count_enable_n_i, l_count_enable_n_i};
	assign addr_w    = {r_addr_i, l_addr_i};

	// Mailbox words sit at the top two addresses of the array
	assign own_box_w   = {`DPCM_MBOX_RIGHT, `DPCM_MBOX_LEFT};
	assign other_box_w = {`DPCM_MBOX_LEFT, `DPCM_MBOX_RIGHT};

	// True when every unmasked bit of the value is one
	function automatic logic f_top_of_range(
		input dpcm_addr_t value,
		input dpcm_addr_t mask
	);
		return (value & mask) == mask;
	endfunction : f_top_of_range

	// Masked bits are forced to one so the carry skips them
	function automatic dpcm_addr_t f_increment(
		input dpcm_addr_t cnt,
		input dpcm_addr_t mask,
		input dpcm_addr_t mirror
	);
		dpcm_addr_t bumped;
		bumped = dpcm_addr_t'((cnt | ~mask) + 1'b1);
		if (f_top_of_range(cnt, mask))
			return mirror;
		return (cnt & ~mask) | (bumped & mask);
	endfunction : f_increment

	// Counter value after this edge; also the address the array sees
	function automatic dpcm_addr_t f_cnt_next(
		input dpcm_op_t   op,
		input dpcm_addr_t cnt,
		input dpcm_addr_t mask,
		input dpcm_addr_t mirror,
		input dpcm_addr_t addr
	);
		dpcm_addr_t res;
		res = cnt;
		unique case (op)
			DPCM_OP_CNT_RST:  res = cnt & ~mask;
			DPCM_OP_CNT_LOAD: res = addr;
			DPCM_OP_CNT_INC:  res = f_increment(cnt, mask, mirror);
			DPCM_OP_CNT_RDBK,
			DPCM_OP_CNT_HOLD,
			DPCM_OP_MSK_RST,
			DPCM_OP_MSK_LOAD,
			DPCM_OP_MSK_RDBK,
			DPCM_OP_RSVD:     res = cnt;
		endcase
		return res;
	endfunction : f_cnt_next

	// Readback turns the address lines around, so no array access goes with it
	function automatic logic f_is_readback(
		input dpcm_op_t op
	);
		return (op == DPCM_OP_CNT_RDBK) || (op == DPCM_OP_MSK_RDBK);
	endfunction : f_is_readback

	// Any load or reset clears the wrap flag; hold and readback keep it
	function automatic logic f_wrap_next(
		input dpcm_op_t   op,
		input dpcm_addr_t cnt_next,
		input dpcm_addr_t mask,
		input logic       wrap_n
	);
		logic res;
		res = wrap_n;
		unique case (op)
			DPCM_OP_CNT_INC:  res = !f_top_of_range(cnt_next, mask);
			DPCM_OP_CNT_RST,
			DPCM_OP_CNT_LOAD,
			DPCM_OP_MSK_RST,
			DPCM_OP_MSK_LOAD: res = 1'b1;
			DPCM_OP_CNT_RDBK,
			DPCM_OP_CNT_HOLD,
			DPCM_OP_MSK_RDBK,
			DPCM_OP_RSVD:     res = wrap_n;
		endcase
		return res;
	endfunction : f_wrap_next

	// Readback drives the address lines; DQ floats only while the port is enabled
	function automatic dpcm_port_t f_readback(
		input dpcm_port_t cur,
		input dpcm_addr_t value,
		input logic       enabled
	);
		dpcm_port_t res;
		res          = cur;
		res.rb_data  = value;
		res.rb_oe_n  = 1'b0;
		res.dq_float = enabled;
		return res;
	endfunction : f_readback

	// Controls are sampled here with no chip select term at all
	assign op_w[0] = dpcm_decode(sel_w[0], clr_n_w[0], ads_n_w[0], en_n_w[0]);
	assign op_w[1] = dpcm_decode(sel_w[1], clr_n_w[1], ads_n_w[1], en_n_w[1]);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_port
			assign cnt_next_w[g] = f_cnt_next(op_w[g], st_r.port[g].cnt,
			                                  st_r.port[g].mask,
			                                  st_r.port[g].mirror, addr_w[g]);

			// Address lines carry no access address during readback
			assign access_ok_w[g] = !f_is_readback(op_w[g]);

			dpcm_port_access u_access (
				.read_not_write_i           (rnw_w[g]),
				.chip_select_low_active_n_i (cs_lo_n_w[g]),
				.chip_select_high_active_i  (cs_hi_w[g]),
				.byte_lane_enable_lo_n_i    (be_lo_n_w[g]),
				.byte_lane_enable_hi_n_i    (be_hi_n_w[g]),
				.access_ok_i                (access_ok_w[g]),
				.eff_addr_i                 (cnt_next_w[g]),
				.own_box_i                  (own_box_w[g]),
				.other_box_i                (other_box_w[g]),
				.enabled_o                  (enabled_w[g]),
				.write_o                    (write_w[g]),
				.read_o                     (read_w[g]),
				.wr_other_box_o             (wr_other_w[g]),
				.rd_own_box_o               (rd_own_w[g])
			);
		end
	endgenerate

	// A write by one port to the other port's mailbox drives that port's flag low
	assign mbox_set_w = {wr_other_w[0], wr_other_w[1]};

	dpcm_mailbox u_mailbox (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.set_i     (mbox_set_w),
		.clr_i     (rd_own_w),
		.flag_n_o  (mbox_flag_n_w)
	);

	always_comb
	begin
		st_nxt = st_r;
		for (int i = 0; i < 2; i++)
		begin
			st_nxt.port[i].cnt     = cnt_next_w[i];
			st_nxt.port[i].rb_oe_n = 1'b1;
			st_nxt.port[i].dq_float = 1'b0;
			st_nxt.port[i].arr_we  = write_w[i];
			st_nxt.port[i].arr_re  = read_w[i];
			st_nxt.port[i].wrap_n  = f_wrap_next(op_w[i], cnt_next_w[i], st_r.port[i].mask,
			                                     st_r.port[i].wrap_n);
			unique case (op_w[i])
				DPCM_OP_CNT_RST:
				begin
					st_nxt.port[i].mirror = st_r.port[i].mirror & ~st_r.port[i].mask;
				end
				DPCM_OP_CNT_LOAD:
				begin
					st_nxt.port[i].mirror = addr_w[i];
				end
				DPCM_OP_CNT_RDBK:
				begin
					st_nxt.port[i] = f_readback(st_nxt.port[i], st_r.port[i].cnt,
					                            enabled_w[i]);
				end
				DPCM_OP_CNT_INC,
				DPCM_OP_CNT_HOLD:
				begin
					st_nxt.port[i].mask = st_r.port[i].mask;
				end
				DPCM_OP_MSK_RST:
				begin
					st_nxt.port[i].mask   = `DPCM_MASK_RST;
				end
				DPCM_OP_MSK_LOAD:
				begin
					st_nxt.port[i].mask   = addr_w[i];
				end
				DPCM_OP_MSK_RDBK:
				begin
					st_nxt.port[i] = f_readback(st_nxt.port[i], st_r.port[i].mask,
					                            enabled_w[i]);
				end
				DPCM_OP_RSVD:
				begin
					// Undefined code: treated as a hold so nothing is disturbed
					st_nxt.port[i].mask = st_r.port[i].mask;
				end
			endcase
		end
	end

	// The reset value is a constant; the global reset needs no clock edge
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				st_r.port[i].cnt      <= `DPCM_CNT_RST;
				st_r.port[i].mask     <= `DPCM_MASK_RST;
				st_r.port[i].mirror   <= `DPCM_MIRROR_RST;
				st_r.port[i].wrap_n   <= 1'b1;
				st_r.port[i].rb_data  <= `DPCM_CNT_RST;
				st_r.port[i].rb_oe_n  <= 1'b1;
				st_r.port[i].dq_float <= 1'b0;
				st_r.port[i].arr_we   <= 1'b0;
				st_r.port[i].arr_re   <= 1'b0;
			end
		end
		else if (ce_i)
		begin
			st_r <= st_nxt;
		end
	end

	assign l_addr_o           = st_r.port[`DPCM_PORT_L].rb_data;
	assign l_addr_oe_n_o      = st_r.port[`DPCM_PORT_L].rb_oe_n;
	assign l_dq_float_o       = st_r.port[`DPCM_PORT_L].dq_float;
	assign l_array_addr_o     = st_r.port[`DPCM_PORT_L].cnt;
	assign l_array_we_o       = st_r.port[`DPCM_PORT_L].arr_we;
	assign l_array_re_o       = st_r.port[`DPCM_PORT_L].arr_re;
	assign l_mailbox_flag_n_o = mbox_flag_n_w[`DPCM_PORT_L];
	assign l_wrap_flag_n_o    = st_r.port[`DPCM_PORT_L].wrap_n;

	assign r_addr_o           = st_r.port[`DPCM_PORT_R].rb_data;
	assign r_addr_oe_n_o      = st_r.port[`DPCM_PORT_R].rb_oe_n;
	assign r_dq_float_o       = st_r.port[`DPCM_PORT_R].dq_float;
	assign r_array_addr_o     = st_r.port[`DPCM_PORT_R].cnt;
	assign r_array_we_o       = st_r.port[`DPCM_PORT_R].arr_we;
	assign r_array_re_o       = st_r.port[`DPCM_PORT_R].arr_re;
	assign r_mailbox_flag_n_o = mbox_flag_n_w[`DPCM_PORT_R];
	assign r_wrap_flag_n_o    = st_r.port[`DPCM_PORT_R].wrap_n;

endmodule : dpcm_top

// >>> verification/dpcm_host.sv
// Host controller model for one port of the burst counter block
`timescale 1ns/100ps
module dpcm_host
	import dpcm_pkg::*;
(
	input  wire logic  ref_clk_i,
	output logic       rnw_o,
	output logic       cs_lo_n_o,
	output logic       cs_hi_o,
	output logic       be_lo_n_o,
	output logic       be_hi_n_o,
	output logic [3:0] ctl_o,
	output dpcm_addr_t addr_o
);
	initial
	begin
		ctl_o = 4'hf;
		rnw_o = 1'h1;
		cs_lo_n_o = 1'h1;
		cs_hi_o = 1'h0;
		be_lo_n_o = 1'h1;
		be_hi_n_o = 1'h1;
		addr_o = 18'h0;
	end

	// ctl is sel, clear, strobe, enable; acc is chip, hi lane, lo lane, read
	task automatic go(input logic [3:0] c, input dpcm_addr_t a, input logic [3:0] acc);
		@(negedge ref_clk_i);
		ctl_o = (c[3:1] == 3'h3) ? 4'hf : c;
		addr_o = a;
		rnw_o = acc[0];
		be_lo_n_o = !acc[1];
		be_hi_n_o = !acc[2];
		cs_lo_n_o = !acc[3];
		cs_hi_o = acc[3];
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		ctl_o = 4'hf;
		cs_lo_n_o = 1'h1;
		be_lo_n_o = 1'h1;
		be_hi_n_o = 1'h1;
		// Idle lines show no stale address
		addr_o = ~a;
	endtask : go
endmodule : dpcm_host

// >>> verification/dpcm_top_props.sv
// Checker for the left counter port and the right mailbox flag
`timescale 1ns/100ps
module dpcm_top_props
	import dpcm_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       resetn_i,
	input wire logic       ce_i,
	input wire logic       l_read_not_write_i,
	input wire logic       l_chip_select_low_active_n_i,
	input wire logic       l_chip_select_high_active_i,
	input wire logic       l_byte_lane_enable_lo_n_i,
	input wire logic       l_byte_lane_enable_hi_n_i,
	input wire logic       l_counter_or_mask_sel_i,
	input wire logic       l_counter_clear_n_i,
	input wire logic       l_address_strobe_n_i,
	input wire logic       l_count_enable_n_i,
	input wire dpcm_addr_t l_addr_i,
	input wire dpcm_addr_t l_addr_o,
	input wire logic       l_addr_oe_n_o,
	input wire logic       l_dq_float_o,
	input wire dpcm_addr_t l_array_addr_o,
	input wire logic       l_array_we_o,
	input wire logic       l_array_re_o,
	input wire logic       l_wrap_flag_n_o,
	input wire logic       r_mailbox_flag_n_o
);
	wire logic [3:0] ctl = {l_counter_or_mask_sel_i, l_counter_clear_n_i,
		l_address_strobe_n_i, l_count_enable_n_i};
	wire logic chip = !l_chip_select_low_active_n_i && l_chip_select_high_active_i;
	wire logic lane = !l_byte_lane_enable_lo_n_i || !l_byte_lane_enable_hi_n_i;
	wire logic wr = chip && lane && !l_read_not_write_i;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_rst_clear:
	assert property ($rose(resetn_i) |-> l_array_addr_o == 18'h0 && l_wrap_flag_n_o
		&& r_mailbox_flag_n_o) else $error("State wrong after reset");
	a_cnt_load:
	assert property (ce_i && ctl == 4'hc |=> l_array_addr_o == $past(l_addr_i)
		&& l_wrap_flag_n_o) else $error("Counter load wrong");
	a_cnt_rdbk:
	assert property (ce_i && ctl == 4'hd |=> !l_addr_oe_n_o
		&& l_addr_o == $past(l_array_addr_o) && l_dq_float_o == $past(chip))
		else $error("Counter readback wrong");
	a_msk_rdbk:
	assert property (ce_i && ctl[3:2] == 2'h0 ##1 ce_i && ctl == 4'hf ##1 ce_i && ctl == 4'h5
		|=> !l_addr_oe_n_o && l_addr_o == 18'h3ffff) else $error("Mask readback wrong");
	a_hold_keep:
	assert property (ce_i && ctl == 4'hf |=> $stable(l_array_addr_o)
		&& $stable(l_wrap_flag_n_o)) else $error("Hold changed state");
	a_cnt_clear:
	assert property (ce_i && ctl[3:2] == 2'h2 |=> l_wrap_flag_n_o
		&& (l_array_addr_o & ~$past(l_array_addr_o)) == 18'h0) else $error("Clear set bits");
	a_rdbk_noacc:
	assert property (ce_i && ctl[2:0] == 3'h5 |=> !l_array_we_o && !l_array_re_o)
		else $error("Readback accessed array");
	a_wr_strobe:
	assert property (ce_i && wr && ctl[2:0] != 3'h5 |=> l_array_we_o && !l_array_re_o)
		else $error("Write strobe missing");
	a_mbox_set:
	assert property (ce_i && wr && ctl == 4'hc && l_addr_i == 18'h3ffff
		|=> !r_mailbox_flag_n_o) else $error("Right mailbox flag not set");
endmodule : dpcm_top_props

bind dpcm_top dpcm_top_props dpcm_top_props_inst (.ref_clk_i, .resetn_i, .ce_i,
	.l_read_not_write_i, .l_chip_select_low_active_n_i, .l_chip_select_high_active_i,
	.l_byte_lane_enable_lo_n_i, .l_byte_lane_enable_hi_n_i, .l_counter_or_mask_sel_i,
	.l_counter_clear_n_i, .l_address_strobe_n_i, .l_count_enable_n_i, .l_addr_i, .l_addr_o,
	.l_addr_oe_n_o, .l_dq_float_o, .l_array_addr_o, .l_array_we_o, .l_array_re_o,
	.l_wrap_flag_n_o, .r_mailbox_flag_n_o);

// >>> verification/tb.sv
// Self-checking bench for the burst counter and mailbox block
`timescale 1ns/100ps
module tb
	import dpcm_pkg::*;
;
	typedef struct packed {logic p; dpcm_addr_t a; logic [3:0] acc; logic [1:0] fl;} dpcm_mb_t;
	localparam logic [3:0] CLD = 4'hc, CRB = 4'hd, INC = 4'he, CRS = 4'h8;
	localparam logic [3:0] MRS = 4'h0, MLD = 4'h4, MRB = 4'h5;
	logic ref_clk_i, resetn_i, ce_i;
	int n_mismatch, checks;
	dpcm_addr_t ql[$], qr[$], v;
	dpcm_mb_t mb [11];
	wire logic [3:0] lc, rc;
	wire logic l_read_not_write_i, l_chip_select_low_active_n_i, l_chip_select_high_active_i;
	wire logic l_byte_lane_enable_lo_n_i, l_byte_lane_enable_hi_n_i, l_counter_or_mask_sel_i;
	wire logic l_counter_clear_n_i, l_address_strobe_n_i, l_count_enable_n_i;
	wire logic r_read_not_write_i, r_chip_select_low_active_n_i, r_chip_select_high_active_i;
	wire logic r_byte_lane_enable_lo_n_i, r_byte_lane_enable_hi_n_i, r_counter_or_mask_sel_i;
	wire logic r_counter_clear_n_i, r_address_strobe_n_i, r_count_enable_n_i;
	wire dpcm_addr_t l_addr_i, l_addr_o, l_array_addr_o, r_addr_i, r_addr_o, r_array_addr_o;
	wire logic l_addr_oe_n_o, l_dq_float_o, l_array_we_o, l_array_re_o;
	wire logic l_mailbox_flag_n_o, l_wrap_flag_n_o, r_addr_oe_n_o, r_dq_float_o;
	wire logic r_array_we_o, r_array_re_o, r_mailbox_flag_n_o, r_wrap_flag_n_o;
	assign {l_counter_or_mask_sel_i, l_counter_clear_n_i, l_address_strobe_n_i} = lc[3:1];
	assign l_count_enable_n_i = lc[0];
	assign {r_counter_or_mask_sel_i, r_counter_clear_n_i, r_address_strobe_n_i} = rc[3:1];
	assign r_count_enable_n_i = rc[0];

	dpcm_top dpcm_top_inst (.*);
	dpcm_host lh (.ref_clk_i, .rnw_o(l_read_not_write_i), .cs_lo_n_o(l_chip_select_low_active_n_i),
		.cs_hi_o(l_chip_select_high_active_i), .be_lo_n_o(l_byte_lane_enable_lo_n_i),
		.be_hi_n_o(l_byte_lane_enable_hi_n_i), .ctl_o(lc), .addr_o(l_addr_i));
	dpcm_host rh (.ref_clk_i, .rnw_o(r_read_not_write_i), .cs_lo_n_o(r_chip_select_low_active_n_i),
		.cs_hi_o(r_chip_select_high_active_i), .be_lo_n_o(r_byte_lane_enable_lo_n_i),
		.be_hi_n_o(r_byte_lane_enable_hi_n_i), .ctl_o(rc), .addr_o(r_addr_i));

	task automatic chk(input string nm, input dpcm_addr_t seen, input dpcm_addr_t exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	initial
	begin
		ref_clk_i = 1'h0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// Readback results are matched in issue order
	always @(negedge ref_clk_i)
	begin
		if (l_addr_oe_n_o === 1'h0)
			chk("l_rdbk", l_addr_o, ql.size() ? ql.pop_front() : 'x);
		if (r_addr_oe_n_o === 1'h0)
			chk("r_rdbk", r_addr_o, qr.size() ? qr.pop_front() : 'x);
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		resetn_i = 1'h0;
		ce_i = 1'h1;
		n_mismatch = 0;
		checks = 0;
		v = dpcm_addr_t'($urandom(32'hb86d3f04));
		mb = '{'{1'h0, 18'h3ffff, 4'he, 2'h2}, '{1'h1, 18'h3ffff, 4'h9, 2'h2},
			'{1'h0, 18'h3ffff, 4'hf, 2'h2}, '{1'h1, 18'h3ffff, 4'hb, 2'h3},
			'{1'h1, 18'h3ffff, 4'hc, 2'h3}, '{1'h1, 18'h3fffe, 4'hc, 2'h1},
			'{1'h1, 18'h3fffe, 4'hf, 2'h1}, '{1'h0, 18'h3fffd, 4'hf, 2'h1},
			'{1'h0, 18'h3fffe, 4'h7, 2'h1}, '{1'h0, 18'h3fffe, 4'hb, 2'h3},
			'{1'h0, 18'h3fffe, 4'he, 2'h3}};
		repeat (4) @(negedge ref_clk_i);
		resetn_i = 1'h1;
		chk("flags", 18'({l_mailbox_flag_n_o, r_mailbox_flag_n_o, l_wrap_flag_n_o,
			r_wrap_flag_n_o}), 18'hf);
		qr.push_back(18'h3ffff);
		rh.go(MRB, 18'h0, 4'h0);
		chk("r_float", 18'(r_dq_float_o), 18'h0);
		ql.push_back(18'h0);
		lh.go(CRB, 18'h0, 4'h0);
		repeat (3)
		begin
			v = dpcm_addr_t'($urandom);
			lh.go(CLD, v, 4'h0);
			chk("l_cnt", l_array_addr_o, v);
			ql.push_back(v);
			lh.go(CRB, ~v, 4'h8);
			chk("l_float", 18'(l_dq_float_o), 18'h1);
		end
		lh.go(MLD, 18'h3f, 4'h0);
		ql.push_back(18'h3f);
		lh.go(MRB, 18'h0, 4'h0);
		lh.go(CLD, 18'h2a508, 4'h0);
		for (int i = 9; i <= 64; i++)
		begin
			lh.go(INC, 18'h0, 4'h0);
			chk("l_cnt", l_array_addr_o, 18'h2a500 | ((i == 64) ? 18'h8 : 18'(i)));
			chk("l_wrap", 18'(l_wrap_flag_n_o), 18'(i != 63));
		end
		lh.go(MLD, 18'h3e, 4'h0);
		lh.go(CLD, 18'h11, 4'h0);
		lh.go(INC, 18'h0, 4'h0);
		chk("l_cnt", l_array_addr_o, 18'h13);
		lh.go(MLD, 18'h3, 4'h0);
		lh.go(CLD, 18'h1234e, 4'h0);
		lh.go(CRS, 18'h3ffff, 4'h0);
		chk("l_cnt", l_array_addr_o, 18'h1234c);
		repeat (4) lh.go(INC, 18'h0, 4'h0);
		chk("l_cnt", l_array_addr_o, 18'h1234c);
		lh.go(MRS, 18'h0, 4'h0);
		ql.push_back(18'h3ffff);
		lh.go(MRB, 18'h0, 4'h8);
		lh.go(CRS, 18'h0, 4'h0);
		chk("l_cnt", l_array_addr_o, 18'h0);
		foreach (mb[k])
		begin
			if (mb[k].p)
				rh.go(CLD, mb[k].a, mb[k].acc);
			else
				lh.go(CLD, mb[k].a, mb[k].acc);
			chk("mbox", 18'({l_mailbox_flag_n_o, r_mailbox_flag_n_o}), 18'(mb[k].fl));
			chk("mb_addr", mb[k].p ? r_array_addr_o : l_array_addr_o, mb[k].a);
			chk("mb_acc", 18'(mb[k].p ? {r_array_we_o, r_array_re_o} : {l_array_we_o, l_array_re_o}),
				18'((mb[k].acc[3] && mb[k].acc[2:1] != 2'h0)
				? {!mb[k].acc[0], mb[k].acc[0]} : 2'h0));
		end
		lh.go(4'hf, 18'h0, 4'h0);
		chk("rdbk_left", 18'(ql.size() + qr.size()), 18'h0);
		stop_test();
	end
endmodule : tb
